// *** hdl/status_regs.svh ***
/*
 * status_regs.svh - offsets, field masks, limits and reset values
 * of the status and event reporting register bank.
 * assumes: included by bare name; holds definitions only.
 */
`ifndef STATUS_REGS_SVH
`define STATUS_REGS_SVH

// ==================================================================
// geometry
`define REG_W              16
`define ADDR_W             8

// ==================================================================
// byte offsets, one aligned word each
`define OFS_OP_COND        8'h00
`define OFS_OP_ENABLE      8'h04
`define OFS_OP_EVENT       8'h08
`define OFS_OP_RISE        8'h0C
`define OFS_OP_FALL        8'h10
`define OFS_WARN_COND      8'h14
`define OFS_WARN_ENABLE    8'h18
`define OFS_WARN_EVENT     8'h1C
`define OFS_WARN_RISE      8'h20
`define OFS_WARN_FALL      8'h24
`define OFS_CLEAR_STATUS   8'h28
`define OFS_SUMMARY        8'h2C

// ==================================================================
// largest accepted values and implemented bit positions
`define OP_MAX             16'h5002
`define OP_MASK            16'h5002
`define WARN_MAX           16'h7CFF
`define WARN_MASK          16'h7CFF

// ==================================================================
// summary register fields
`define SUM_OP_BIT         0
`define SUM_WARN_BIT       1
`define SUM_REFUSED_BIT    2

// ==================================================================
// reset values
`define WORD_RST           16'h0000

`endif

// *** hdl/status_pkg.sv ***
/*
 * status_pkg.sv - types shared by the status reporting bank.
 * assumes: status_regs.svh sits on the include path.
 */
`include "status_regs.svh"

package status_pkg;

    // ==============================================================
    // words and addresses
    typedef logic [`REG_W-1:0]  word_t;
    typedef logic [`ADDR_W-1:0] addr_t;

    // ==============================================================
    // register selector decoded from the address
    typedef enum logic [3:0] {
        SEL_OP_COND     = 4'h0,
        SEL_OP_ENABLE   = 4'h1,
        SEL_OP_EVENT    = 4'h2,
        SEL_OP_RISE     = 4'h3,
        SEL_OP_FALL     = 4'h4,
        SEL_WARN_COND   = 4'h5,
        SEL_WARN_ENABLE = 4'h6,
        SEL_WARN_EVENT  = 4'h7,
        SEL_WARN_RISE   = 4'h8,
        SEL_WARN_FALL   = 4'h9,
        SEL_CLEAR       = 4'hA,
        SEL_SUMMARY     = 4'hB,
        SEL_NONE        = 4'hF
    } reg_sel_t;

    // ==============================================================
    // state of one register group
    typedef struct packed {
        word_t cond;
        logic  primed;
        word_t enable;
        word_t rise;
        word_t fall;
        word_t event_bits;
    } group_state_t;

    // ==============================================================
    // state of the bank front end
    typedef struct packed {
        word_t rdata;
        logic  clear_pulse;
        logic  refuse_pulse;
        logic  refused_sticky;
    } bank_state_t;

endpackage

// *** hdl/event_group.sv ***
/*
 * event_group.sv - one condition / filter / event / enable group.
 * assumes: condition input synchronous to mclk; strobes one cycle.
 */
`timescale 1ns/1ps
`include "status_regs.svh"

module event_group import status_pkg::*; #(
    parameter word_t MASK = 16'hFFFF
) (
    // clock and reset
    input  wire logic  mclk,
    input  wire logic  rst,
    // condition source
    input  wire word_t cond_in,
    // register writes
    input  wire word_t wdata,
    input  wire logic  enable_wr,
    input  wire logic  rise_wr,
    input  wire logic  fall_wr,
    input  wire logic  clear,
    // register contents
    output word_t      cond,
    output word_t      enable,
    output word_t      rising_edge_filter,
    output word_t      falling_edge_filter,
    output word_t      event_bits,
    output logic       summary
);

    group_state_t s_q;
    group_state_t s_d;
    word_t        sample;
    word_t        hit;

    assign sample = cond_in & MASK;

    // ==============================================================
    // per-bit transition filter
    for (genvar i = 0; i < `REG_W; i++) begin : g_bit
        // first sample after reset is no transition
        assign hit[i] = s_q.primed &
                        ((s_q.rise[i] & ~s_q.cond[i] &  sample[i]) |  // RULE6 RULE13
                         (s_q.fall[i] &  s_q.cond[i] & ~sample[i]));  // RULE5 RULE12
    end                                                               // RULE7 RULE14

    // ==============================================================
    // next state
    always_comb begin
        s_d        = s_q;
        s_d.cond   = sample;
        s_d.primed = 1'b1;
        if (enable_wr) begin
            s_d.enable = wdata & MASK;
        end
        if (rise_wr) begin
            s_d.rise = wdata & MASK;
        end
        if (fall_wr) begin
            s_d.fall = wdata & MASK;
        end
        if (clear) begin
            s_d.event_bits = `WORD_RST;                              // RULE15
        end
        // set beats clear in the same cycle
        s_d.event_bits = s_d.event_bits | hit;                       // RULE16
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ==============================================================
    // outputs
    assign cond                = s_q.cond;
    assign enable              = s_q.enable;
    assign rising_edge_filter  = s_q.rise;
    assign falling_edge_filter = s_q.fall;
    assign event_bits          = s_q.event_bits;
    assign summary             = |(s_q.event_bits & s_q.enable);     // RULE17

endmodule // event_group

// *** hdl/status_event_reporting.sv ***
/*
 * status_event_reporting.sv - operation and warning status groups
 * behind a plain register port, with clear-status and summaries.
 *
 * register map, byte offsets, 16-bit words:
 *   0x00 operation condition        read only
 *   0x04 operation event enable     read/write
 *   0x08 operation event            read only, sticky
 *   0x0c operation rising filter    read/write
 *   0x10 operation falling filter   read/write
 *   0x14 warning condition          read only
 *   0x18 warning event enable       read/write
 *   0x1c warning event              read only, sticky
 *   0x20 warning rising filter      read/write
 *   0x24 warning falling filter     read/write
 *   0x28 clear-status               write only, any data
 *   0x2c summary                    bit0 operation, bit1 warning,
 *                                   bit2 refused-write flag
 * assumes: one clock mclk, synchronous active-high rst, strobes one
 * cycle long and never both at once, read data taken next cycle.
 */
// Behaviour
// RULE1 - operation condition readable, up to 20482
// RULE2 - operation enable stored and read back
// RULE3 - latched operation event readable
// RULE4 - operation rising and falling filters kept
// RULE5 - falling filter bit catches one-to-zero
// RULE6 - rising filter bit catches zero-to-one
// RULE7 - both bits any change; none ignored
// RULE8 - warning condition readable, up to 31999
// RULE9 - warning enable stored and read back
// RULE10 - latched warning event readable
// RULE11 - warning rising and falling filters kept
// RULE12 - warning falling filter catches one-to-zero
// RULE13 - warning rising filter catches zero-to-one
// RULE14 - warning both bits any change; none ignored
// RULE15 - clear-status zeroes events and outside state
// RULE16 - events sticky; 16-bit, unused bits zero
// RULE17 - group summary is OR of enabled events
`timescale 1ns/1ps
`include "status_regs.svh"

module status_event_reporting import status_pkg::*; #(
    parameter word_t OP_MASK   = `OP_MASK,
    parameter word_t OP_MAX    = `OP_MAX,
    parameter word_t WARN_MASK = `WARN_MASK,
    parameter word_t WARN_MAX  = `WARN_MAX
) (
    // clock and reset
    input  wire logic  mclk,
    input  wire logic  rst,
    // register port
    input  wire addr_t addr,
    input  wire word_t wdata,
    input  wire logic  wr_stb,
    input  wire logic  rd_stb,
    output word_t      rdata,
    // condition sources
    input  wire word_t operation_condition_in,
    input  wire word_t warning_condition_in,
    // summaries and notifications
    output logic       operation_summary,
    output logic       warning_summary,
    output logic       clear_status_pulse,
    output logic       write_refused_pulse
);

    // ==============================================================
    // declarations
    bank_state_t s_q;
    bank_state_t s_d;
    reg_sel_t    sel;
    // write decode
    logic        op_range_ok;
    logic        warn_range_ok;
    logic        op_enable_wr;
    logic        op_rise_wr;
    logic        op_fall_wr;
    logic        warn_enable_wr;
    logic        warn_rise_wr;
    logic        warn_fall_wr;
    logic        clear_wr;
    logic        refused;
    // read path
    word_t       read_word;
    word_t       summary_word;

    // operation group contents
    word_t       operation_condition;
    word_t       operation_event_enable;
    word_t       operation_event;
    word_t       op_rising_edge_filter;
    word_t       op_falling_edge_filter;
    logic        op_summary;

    // warning group contents
    word_t       warning_condition;
    word_t       warning_event_enable;
    word_t       warning_event;
    word_t       warn_rising_edge_filter;
    word_t       warn_falling_edge_filter;
    logic        warn_summary;

    // ==============================================================
    // address decode
    always_comb begin
        unique case (addr)
            `OFS_OP_COND: begin
                sel = SEL_OP_COND;
            end
            `OFS_OP_ENABLE: begin
                sel = SEL_OP_ENABLE;
            end
            `OFS_OP_EVENT: begin
                sel = SEL_OP_EVENT;
            end
            `OFS_OP_RISE: begin
                sel = SEL_OP_RISE;
            end
            `OFS_OP_FALL: begin
                sel = SEL_OP_FALL;
            end
            `OFS_WARN_COND: begin
                sel = SEL_WARN_COND;
            end
            `OFS_WARN_ENABLE: begin
                sel = SEL_WARN_ENABLE;
            end
            `OFS_WARN_EVENT: begin
                sel = SEL_WARN_EVENT;
            end
            `OFS_WARN_RISE: begin
                sel = SEL_WARN_RISE;
            end
            `OFS_WARN_FALL: begin
                sel = SEL_WARN_FALL;
            end
            `OFS_CLEAR_STATUS: begin
                sel = SEL_CLEAR;
            end
            `OFS_SUMMARY: begin
                sel = SEL_SUMMARY;
            end
            // unmapped: writes dropped, reads return zero
            default: begin
                sel = SEL_NONE;
            end
        endcase
    end

    // ==============================================================
    // write qualification
    // out-of-range values are refused whole, not clipped,
    // so a stale setting is never half overwritten
    assign op_range_ok    = (wdata <= OP_MAX);
    assign warn_range_ok  = (wdata <= WARN_MAX);

    always_comb begin
        op_enable_wr   = 1'b0;
        op_rise_wr     = 1'b0;
        op_fall_wr     = 1'b0;
        warn_enable_wr = 1'b0;
        warn_rise_wr   = 1'b0;
        warn_fall_wr   = 1'b0;
        clear_wr       = 1'b0;
        refused        = 1'b0;
        if (wr_stb) begin
            unique case (sel)
                SEL_OP_ENABLE: begin
                    op_enable_wr = op_range_ok;                     // RULE2
                    refused      = !op_range_ok;
                end
                SEL_OP_RISE: begin
                    op_rise_wr = op_range_ok;                       // RULE4
                    refused    = !op_range_ok;
                end
                SEL_OP_FALL: begin
                    op_fall_wr = op_range_ok;                       // RULE4
                    refused    = !op_range_ok;
                end
                SEL_WARN_ENABLE: begin
                    warn_enable_wr = warn_range_ok;                 // RULE9
                    refused        = !warn_range_ok;
                end
                SEL_WARN_RISE: begin
                    warn_rise_wr = warn_range_ok;                   // RULE11
                    refused      = !warn_range_ok;
                end
                SEL_WARN_FALL: begin
                    warn_fall_wr = warn_range_ok;                   // RULE11
                    refused      = !warn_range_ok;
                end
                SEL_CLEAR: begin
                    clear_wr = 1'b1;                                // RULE15
                end
                // read-only and unmapped words drop the write
                default: begin
                    refused = 1'b0;
                end
            endcase
        end
    end

    // ==============================================================
    // operation group
    event_group #(
        .MASK                (OP_MASK)
    ) u_operation (
        // clock and reset
        .mclk                (mclk),
        .rst                 (rst),
        // condition source
        .cond_in             (operation_condition_in),
        // register writes
        .wdata               (wdata),
        .enable_wr           (op_enable_wr),
        .rise_wr             (op_rise_wr),
        .fall_wr             (op_fall_wr),
        .clear               (clear_wr),
        // register contents
        .cond                (operation_condition),
        .enable              (operation_event_enable),
        .rising_edge_filter  (op_rising_edge_filter),
        .falling_edge_filter (op_falling_edge_filter),
        .event_bits          (operation_event),
        .summary             (op_summary)
    );

    // ==============================================================
    // warning group
    event_group #(
        .MASK                (WARN_MASK)
    ) u_warning (
        // clock and reset
        .mclk                (mclk),
        .rst                 (rst),
        // condition source
        .cond_in             (warning_condition_in),
        // register writes
        .wdata               (wdata),
        .enable_wr           (warn_enable_wr),
        .rise_wr             (warn_rise_wr),
        .fall_wr             (warn_fall_wr),
        .clear               (clear_wr),
        // register contents
        .cond                (warning_condition),
        .enable              (warning_event_enable),
        .rising_edge_filter  (warn_rising_edge_filter),
        .falling_edge_filter (warn_falling_edge_filter),
        .event_bits          (warning_event),
        .summary             (warn_summary)
    );

    // ==============================================================
    // summary word
    always_comb begin
        // bits above the refused flag read zero
        summary_word                   = `WORD_RST;
        summary_word[`SUM_OP_BIT]      = op_summary;                // RULE17
        summary_word[`SUM_WARN_BIT]    = warn_summary;              // RULE17
        summary_word[`SUM_REFUSED_BIT] = s_q.refused_sticky;
    end

    // ==============================================================
    // read mux
    // reads have no side effect; events leave only by clear-status
    always_comb begin
        unique case (sel)
            SEL_OP_COND: begin
                read_word = operation_condition;                    // RULE1
            end
            SEL_OP_ENABLE: begin
                read_word = operation_event_enable;                 // RULE2
            end
            SEL_OP_EVENT: begin
                read_word = operation_event;                        // RULE3
            end
            SEL_OP_RISE: begin
                read_word = op_rising_edge_filter;                  // RULE4
            end
            SEL_OP_FALL: begin
                read_word = op_falling_edge_filter;                 // RULE4
            end
            SEL_WARN_COND: begin
                read_word = warning_condition;                      // RULE8
            end
            SEL_WARN_ENABLE: begin
                read_word = warning_event_enable;                   // RULE9
            end
            SEL_WARN_EVENT: begin
                read_word = warning_event;                          // RULE10
            end
            SEL_WARN_RISE: begin
                read_word = warn_rising_edge_filter;                // RULE11
            end
            SEL_WARN_FALL: begin
                read_word = warn_falling_edge_filter;               // RULE11
            end
            SEL_SUMMARY: begin
                read_word = summary_word;
            end
            // clear-status is write only and reads as zero
            default: begin
                read_word = `WORD_RST;                              // RULE16
            end
        endcase
    end

    // ==============================================================
    // front-end state
    always_comb begin
        s_d              = s_q;
        // read data stands for exactly one cycle
        s_d.rdata        = rd_stb ? read_word : `WORD_RST;
        s_d.clear_pulse  = clear_wr;                                // RULE15
        s_d.refuse_pulse = refused;
        if (clear_wr) begin
            s_d.refused_sticky = 1'b0;
        end
        // a refusal in the clearing cycle survives
        if (refused) begin
            s_d.refused_sticky = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ==============================================================
    // outputs
    assign rdata               = s_q.rdata;
    assign operation_summary   = op_summary;
    assign warning_summary     = warn_summary;
    // standard event register, status byte and error queue live
    // outside; they clear on this pulse
    assign clear_status_pulse  = s_q.clear_pulse;                   // RULE15
    assign write_refused_pulse = s_q.refuse_pulse;

endmodule // status_event_reporting

// *** sim/status_event_reporting_assertions.sv ***
/*
 * status_event_reporting_assertions.sv - port-level checks of the bank.
 * assumes: bound to the top module; single clock, synchronous rst.
 */
`timescale 1ns/1ps
`include "status_regs.svh"

module status_event_reporting_assertions import status_pkg::*; #(
    parameter word_t OP_MASK   = `OP_MASK,
    parameter word_t OP_MAX    = `OP_MAX,
    parameter word_t WARN_MASK = `WARN_MASK,
    parameter word_t WARN_MAX  = `WARN_MAX
) (
    // clock and reset
    input wire logic  mclk,
    input wire logic  rst,
    // register port
    input wire addr_t addr,
    input wire word_t wdata,
    input wire logic  wr_stb,
    input wire logic  rd_stb,
    input wire word_t rdata,
    // condition sources
    input wire word_t operation_condition_in,
    input wire word_t warning_condition_in,
    // summaries and notifications
    input wire logic  operation_summary,
    input wire logic  warning_summary,
    input wire logic  clear_status_pulse,
    input wire logic  write_refused_pulse
);
    // ==========================================================
    // decode helpers
    logic op_a;
    logic warn_a;
    logic op_bad;
    logic warn_bad;
    logic clr_wr;
    assign op_a = addr inside {`OFS_OP_ENABLE, `OFS_OP_RISE, `OFS_OP_FALL};
    assign warn_a = addr inside {`OFS_WARN_ENABLE, `OFS_WARN_RISE, `OFS_WARN_FALL};
    assign op_bad = wr_stb && op_a && (wdata > OP_MAX);
    assign warn_bad = wr_stb && warn_a && (wdata > WARN_MAX);
    assign clr_wr = wr_stb && (addr == `OFS_CLEAR_STATUS);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ==========================================================
    // assertions
    chk_rdata_idle: assert property (!rd_stb |=> rdata == 16'h0000)
        else $error("read data not zero outside a read");
    chk_op_unused: assert property (rd_stb &&
        (op_a || addr == `OFS_OP_EVENT) |=> (rdata & ~OP_MASK) == 16'h0000)
        else $error("operation word shows unused bits");
    chk_warn_unused: assert property (rd_stb &&
        (warn_a || addr == `OFS_WARN_EVENT) |=> (rdata & ~WARN_MASK) == 16'h0000)
        else $error("warning word shows unused bits");
    chk_op_cond: assert property (rd_stb && addr == `OFS_OP_COND && !$past(rst)
        |=> rdata == ($past(operation_condition_in, 2) & OP_MASK))
        else $error("operation condition read wrong");
    chk_warn_cond: assert property (rd_stb && addr == `OFS_WARN_COND && !$past(rst)
        |=> rdata == ($past(warning_condition_in, 2) & WARN_MASK))
        else $error("warning condition read wrong");
    chk_clear_pulse: assert property (clr_wr |=> clear_status_pulse)
        else $error("clear-status pulse missing");
    chk_clear_quiet: assert property (!clr_wr |=> !clear_status_pulse)
        else $error("clear-status pulse without a clear");
    chk_op_refuse: assert property (op_bad |=> write_refused_pulse)
        else $error("oversized operation write not refused");
    chk_warn_refuse: assert property (warn_bad |=> write_refused_pulse)
        else $error("oversized warning write not refused");
    chk_refuse_quiet: assert property (!(op_bad || warn_bad)
        |=> !write_refused_pulse)
        else $error("refused pulse without a bad write");
    chk_summary_read: assert property (rd_stb && addr == `OFS_SUMMARY
        |=> rdata[1:0] == {$past(warning_summary), $past(operation_summary)})
        else $error("summary word disagrees with summary outputs");

    // ==========================================================
    // covers
    cover property (op_bad ##1 write_refused_pulse);
    cover property (clr_wr ##1 clear_status_pulse);
    cover property ($rose(operation_summary) ##[1:40] $rose(warning_summary));
endmodule // status_event_reporting_assertions

// *** sim/status_host.sv ***
/*
 * status_host.sv - remote host model driving the register port.
 * assumes: tasks called from a process just after a rising edge.
 */
`timescale 1ns/1ps

module status_host import status_pkg::*; (
    // clock
    input  wire logic  mclk,
    // register port
    output addr_t      addr,
    output word_t      wdata,
    output logic       wr_stb,
    output logic       rd_stb,
    input  wire word_t rdata
);
    initial begin
        addr = 8'h00;
        wdata = 16'h0000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end

    // in-range values only, except where a caller asks for a refusal
    task automatic wr(input addr_t a, input word_t d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        // idle bus shows garbage, not the last value
        addr <= ~a;
        wdata <= ~d;
    endtask

    task automatic rd(input addr_t a, output word_t d);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        addr <= ~a;
        @(posedge mclk);
        d = rdata;
    endtask
endmodule // status_host

// *** sim/tb_status_event_reporting.sv ***
/*
 * tb_status_event_reporting.sv - self-checking bench of the status bank.
 * assumes: host model and checker compiled before this file.
 */
`timescale 1ns/1ps
`include "status_regs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end

module tb_status_event_reporting import status_pkg::*; ();
    logic  mclk = 1'b0;
    logic  rst = 1'b1;
    addr_t addr;
    word_t wdata;
    logic  wr_stb;
    logic  rd_stb;
    word_t rdata;
    word_t op_in = 16'h0000;
    word_t warn_in = 16'h0000;
    logic  op_sum;
    logic  warn_sum;
    logic  clr_p;
    logic  ref_p;
    int    n_fail = 0;
    int    checks = 0;

    always #4 mclk = ~mclk;

    status_host i_status_host (.mclk(mclk), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));

    status_event_reporting i_status_event_reporting (.mclk(mclk), .rst(rst),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .operation_condition_in(op_in), .warning_condition_in(warn_in),
        .operation_summary(op_sum), .warning_summary(warn_sum),
        .clear_status_pulse(clr_p), .write_refused_pulse(ref_p));

    // ==========================================================
    // shared helpers
    task automatic rd_chk(input addr_t a, input word_t e);
        word_t d;
        i_status_host.rd(a, d);
        `CHK(d, e)
    endtask

    task automatic set_cond(input bit w, input word_t v);
        @(posedge mclk);
        if (w) warn_in <= v;
        else op_in <= v;
        repeat (2) @(posedge mclk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        for (int a = 0; a <= 'h30; a += 4) rd_chk(addr_t'(a), 16'h0000);
    endtask

    task automatic t_regs();
        addr_t rw[6] = '{`OFS_OP_ENABLE, `OFS_OP_RISE, `OFS_OP_FALL,
                         `OFS_WARN_ENABLE, `OFS_WARN_RISE, `OFS_WARN_FALL};
        word_t mx;
        word_t m;
        for (int i = 0; i < 6; i++) begin
            mx = (i < 3) ? `OP_MAX : `WARN_MAX;
            m = (i < 3) ? `OP_MASK : `WARN_MASK;
            i_status_host.wr(rw[i], mx);
            rd_chk(rw[i], mx);
            i_status_host.wr(rw[i], 16'h0301);
            rd_chk(rw[i], 16'h0301 & m);
            i_status_host.wr(rw[i], mx + 16'h0001);
            rd_chk(rw[i], 16'h0301 & m);
        end
        i_status_host.wr(`OFS_OP_COND, 16'h5002);
        rd_chk(`OFS_OP_COND, 16'h0000);
        rd_chk(`OFS_SUMMARY, 16'h0004);
    endtask

    task automatic t_clear();
        i_status_host.wr(`OFS_CLEAR_STATUS, 16'hFFFF);
        rd_chk(`OFS_OP_EVENT, 16'h0000);
        rd_chk(`OFS_WARN_EVENT, 16'h0000);
        rd_chk(`OFS_SUMMARY, 16'h0000);
        @(negedge mclk);
        `CHK({op_sum, warn_sum}, 2'b00)
    endtask

    task automatic t_filt(input bit w, input word_t rise, input word_t fall);
        addr_t b;
        word_t m;
        b = w ? `OFS_WARN_COND : `OFS_OP_COND;
        m = w ? `WARN_MASK : `OP_MASK;
        i_status_host.wr(b + 8'h0C, rise);
        i_status_host.wr(b + 8'h10, fall);
        // enable only the both-edge positions
        i_status_host.wr(b + 8'h04, rise & fall);
        set_cond(w, 16'hFFFF);
        rd_chk(b, m);
        rd_chk(b + 8'h08, rise & m);
        @(negedge mclk);
        `CHK(w ? warn_sum : op_sum, |(rise & fall & m))
        set_cond(w, 16'h0000);
        rd_chk(b + 8'h08, (rise | fall) & m);
        rd_chk(b + 8'h08, (rise | fall) & m);
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_clear();
        t_filt(1'b0, 16'h4002, 16'h1002);
        t_filt(1'b1, 16'h0081, 16'h4001);
        rd_chk(`OFS_SUMMARY, 16'h0003);
        t_clear();
        t_filt(1'b0, 16'h0000, 16'h0000);
        t_filt(1'b1, 16'h0000, 16'h0000);
        tally_and_finish();
    end

    initial begin
        #100000;
        n_fail++;
        tally_and_finish();
    end
endmodule // tb_status_event_reporting

bind status_event_reporting status_event_reporting_assertions #(
    .OP_MASK(OP_MASK), .OP_MAX(OP_MAX), .WARN_MASK(WARN_MASK), .WARN_MAX(WARN_MAX)
) i_status_event_reporting_assertions (.mclk(mclk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .operation_condition_in(operation_condition_in),
    .warning_condition_in(warning_condition_in),
    .operation_summary(operation_summary), .warning_summary(warning_summary),
    .clear_status_pulse(clear_status_pulse), .write_refused_pulse(write_refused_pulse));
